// File: hw/sbp_pkg.sv
/*
 * sbp_pkg: shared constants and carrier types for the split-budget and
 * power-management capability register block.
 * Assumes a single core clock and an active-low asynchronous reset.
 */
package sbp_pkg;

	// configuration offsets (byte addresses, dword aligned)
	localparam logic [7:0]  SPLIT_STAT_OFF  = 8'h84;
	localparam logic [7:0]  DS_SPLIT_OFF    = 8'h8c;
	localparam logic [7:0]  PM_CAP_OFF      = 8'h90;

	// downstream split register and split status delayed bit
	localparam logic [15:0] SPLIT_CAP_ADQ   = 16'h0010;
	localparam logic [15:0] LIMIT_RST       = 16'h0010;
	localparam logic [15:0] LIMIT_ALL       = 16'hffff;
	localparam logic [15:0] LIMIT_FREE_MIN  = 16'h0100;
	localparam int          LIMIT_LSB       = 16;
	localparam int          DELAYED_BIT     = 21;

	// power-management capability fields
	localparam logic [7:0]  PM_ID           = 8'h01;
	localparam logic [7:0]  PM_NEXT_PTR     = 8'ha8;
	localparam logic [2:0]  PM_VERSION      = 3'h3;
	localparam logic        PM_WAKE_CLK     = 1'h0;
	localparam logic        PM_RSVD20       = 1'h0;
	localparam logic        PM_DSI          = 1'h0;
	localparam logic [2:0]  PM_AUX_CURRENT  = 3'h1;
	localparam logic        PM_D1_SUP       = 1'h0;
	localparam logic        PM_D2_SUP       = 1'h0;
	localparam logic [4:0]  PM_WAKE_SUP     = 5'h19;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [3:0]  be;
		logic [31:0] wdata;
	} sbp_cfg_req_t;

	typedef struct packed {
		logic        pend;
		logic [15:0] size;
		logic [15:0] outst;
		logic        fwd;
		logic        held;
		logic        ready;
	} sbp_gate_st_t;

	typedef struct packed {
		logic [15:0] limit;
		logic        delayed;
		logic [31:0] rdata;
		logic        ack;
	} sbp_reg_st_t;

endpackage : sbp_pkg

// File: hw/sbp_split_gate.sv
/*
 * sbp_split_gate: decides whether a pending split request may be forwarded
 * under the commitment limit and tracks the outstanding completion budget.
 * Assumes the requester holds one request at a time through the ready flag
 * and that completions report their drained size on the release port.
 */
module sbp_split_gate (
	input  wire logic        i_clk,        // core clock
	input  wire logic        i_rstn,       // async reset, active low
	input  wire logic [15:0] i_limit,      // commitment limit in ADQs
	input  wire logic        i_req_valid,  // split request offered
	input  wire logic [15:0] i_req_size,   // request size in ADQs
	output logic             o_req_ready,  // gate can take a request
	input  wire logic        i_rel_valid,  // completion drained
	input  wire logic [15:0] i_rel_size,   // drained size in ADQs
	output logic             o_fwd,        // request forwarded, pulse
	output logic             o_held,       // pending request held
	output logic [15:0]      o_outst       // outstanding ADQs
);

	sbp_pkg::sbp_gate_st_t s_r;
	sbp_pkg::sbp_gate_st_t s_nxt;
	logic                  unlim;
	logic [16:0]           sum;
	logic [16:0]           grown;
	logic [15:0]           base;

	always_comb begin
		unlim = (i_limit == sbp_pkg::LIMIT_ALL) ||
			(i_limit >= sbp_pkg::LIMIT_FREE_MIN);
		// release trims the new count, but the limit check still uses the count before the release
		if (i_rel_valid) begin
			base = (s_r.outst > i_rel_size) ? (s_r.outst - i_rel_size) : 16'h0000;
		end else begin
			base = s_r.outst;
		end
		sum   = {1'b0, s_r.outst} + {1'b0, s_r.size};
		grown = {1'b0, base} + {1'b0, s_r.size};
		s_nxt      = s_r;
		s_nxt.fwd  = 1'b0;
		s_nxt.held = 1'b0;
		s_nxt.outst = base;
		if (s_r.pend) begin
			if (unlim || (sum <= {1'b0, i_limit})) begin
				s_nxt.fwd   = 1'b1;
				s_nxt.pend  = 1'b0;
				// saturate: in unlimited mode the count may outrun 16 bits
				s_nxt.outst = grown[16] ? 16'hffff : grown[15:0];
			end else begin
				s_nxt.held = 1'b1;
			end
		end else if (i_req_valid) begin
			s_nxt.pend = 1'b1;
			s_nxt.size = i_req_size;
		end
		s_nxt.ready = ~s_nxt.pend;
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			s_r <= '{pend: 1'b0, size: 16'h0000, outst: 16'h0000,
				fwd: 1'b0, held: 1'b0, ready: 1'b1};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign o_req_ready = s_r.ready;
	assign o_fwd       = s_r.fwd;
	assign o_held      = s_r.held;
	assign o_outst     = s_r.outst;

	property p_all_ones_forwards;
		@(posedge i_clk) disable iff (!i_rstn)
		(s_r.pend && i_limit == 16'hffff) |=> (o_fwd && !o_held);
	endproperty
	a_all_ones_forwards: assert property (p_all_ones_forwards)
		else $error("all-ones limit did not forward");

	property p_large_limit_forwards;
		@(posedge i_clk) disable iff (!i_rstn)
		// ready comes back in the same cycle as the forward pulse
		(s_r.pend && i_limit >= 16'h0100) |=> (o_fwd && o_req_ready);
	endproperty
	a_large_limit_forwards: assert property (p_large_limit_forwards)
		else $error("large limit did not forward");

	property p_over_limit_held;
		@(posedge i_clk) disable iff (!i_rstn)
		(s_r.pend && i_limit < 16'h0100 && sum > {1'b0, i_limit})
			|=> (o_held && !o_fwd && !o_req_ready);
	endproperty
	a_over_limit_held: assert property (p_over_limit_held)
		else $error("over-limit request not held");

endmodule : sbp_split_gate

// File: hw/sbp_split_pm_regs.sv
/*
 * sbp_split_pm_regs: downstream split budget register, split status flag and
 * the read-only power-management capability word, reached by config access.
 * Assumes config reads and writes are one-cycle strobes on the core clock and
 * that the forwarding logic offers split requests through the gate handshake.
 */
// Function
// - split low half reads fixed 16 ADQ completion buffer capacity, read-only
// - split upper half is writable commitment limit, reset equal to capacity
// - limit all ones forwards every split request regardless of free space
// - limit 0x0100 or above forwards accepted requests of any size
// - over-limit request held, sets sticky delayed flag cleared by writing one
// - capability byte zero reads power-management identifier 0x01
// - capability byte one reads next pointer 0xa8
// - version field reads binary 011
// - wake-clock flag reads zero
// - device-specific-initialization flag reads zero
// - D1 support flag reads zero
// - D2 support flag reads zero
// - wake-support field reads binary 11001
module sbp_split_pm_regs (
	input  wire logic                 i_clk,        // core clock, 10 MHz
	input  wire logic                 i_rstn,       // async reset, active low
	input  wire sbp_pkg::sbp_cfg_req_t i_cfg,       // config access strobe
	output logic [31:0]               o_cfg_rdata,  // read data
	output logic                      o_cfg_ack,    // access done, pulse
	input  wire logic                 i_req_valid,  // split request offered
	input  wire logic [15:0]          i_req_size,   // request size in ADQs
	output logic                      o_req_ready,  // request can be taken
	input  wire logic                 i_rel_valid,  // completion drained
	input  wire logic [15:0]          i_rel_size,   // drained size in ADQs
	output logic                      o_fwd,        // request forwarded, pulse
	output logic                      o_held        // request held by limit
);

	sbp_pkg::sbp_reg_st_t s_r;
	sbp_pkg::sbp_reg_st_t s_nxt;
	logic [31:0]          pm_word;
	logic [31:0]          stat_word;
	logic [15:0]          outst;
	logic                 hit_split;
	logic                 hit_pm;
	logic                 hit_stat;

	sbp_split_gate u_gate (
		.i_clk       (i_clk),
		.i_rstn      (i_rstn),
		.i_limit     (s_r.limit),
		.i_req_valid (i_req_valid),
		.i_req_size  (i_req_size),
		.o_req_ready (o_req_ready),
		.i_rel_valid (i_rel_valid),
		.i_rel_size  (i_rel_size),
		.o_fwd       (o_fwd),
		.o_held      (o_held),
		.o_outst     (outst)
	);

	always_comb begin
		pm_word = {sbp_pkg::PM_WAKE_SUP,
			sbp_pkg::PM_D2_SUP,
			sbp_pkg::PM_D1_SUP,
			sbp_pkg::PM_AUX_CURRENT,
			sbp_pkg::PM_DSI,
			sbp_pkg::PM_RSVD20,
			sbp_pkg::PM_WAKE_CLK,
			sbp_pkg::PM_VERSION,
			sbp_pkg::PM_NEXT_PTR,
			sbp_pkg::PM_ID};
		stat_word = 32'h0000_0000;
		stat_word[sbp_pkg::DELAYED_BIT] = s_r.delayed;
		hit_split = (i_cfg.addr[7:2] == sbp_pkg::DS_SPLIT_OFF[7:2]);
		hit_pm    = (i_cfg.addr[7:2] == sbp_pkg::PM_CAP_OFF[7:2]);
		hit_stat  = (i_cfg.addr[7:2] == sbp_pkg::SPLIT_STAT_OFF[7:2]);

		s_nxt     = s_r;
		s_nxt.ack = i_cfg.wr || i_cfg.rd;
		if (i_cfg.wr && hit_split) begin
			// the capacity half has no storage, so only the limit lanes land
			if (i_cfg.be[2]) begin
				s_nxt.limit[7:0] = i_cfg.wdata[23:16];
			end
			if (i_cfg.be[3]) begin
				s_nxt.limit[15:8] = i_cfg.wdata[31:24];
			end
		end
		if (i_cfg.wr && hit_stat && i_cfg.be[2] && i_cfg.wdata[sbp_pkg::DELAYED_BIT]) begin
			s_nxt.delayed = 1'b0;
		end
		// a hold in the same cycle as the clear wins
		if (o_held) begin
			s_nxt.delayed = 1'b1;
		end
		if (i_cfg.rd) begin
			if (hit_split) begin
				s_nxt.rdata = {s_r.limit, sbp_pkg::SPLIT_CAP_ADQ};
			end else if (hit_pm) begin
				s_nxt.rdata = pm_word;
			end else if (hit_stat) begin
				s_nxt.rdata = stat_word;
			end else begin
				s_nxt.rdata = 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			s_r <= '{limit: sbp_pkg::LIMIT_RST, delayed: 1'b0,
				rdata: 32'h0000_0000, ack: 1'b0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign o_cfg_rdata = s_r.rdata;
	assign o_cfg_ack   = s_r.ack;

	sequence s_rd_split;
		i_cfg.rd && !i_cfg.wr && i_cfg.addr[7:2] == 6'h23;
	endsequence

	sequence s_rd_pm;
		i_cfg.rd && !i_cfg.wr && i_cfg.addr[7:2] == 6'h24;
	endsequence

	property p_cap_ro;
		@(posedge i_clk) disable iff (!i_rstn)
		s_rd_split |=> (o_cfg_ack && o_cfg_rdata[15:0] == 16'h0010);
	endproperty
	a_cap_ro: assert property (p_cap_ro)
		else $error("split capacity field wrong");

	property p_limit_write;
		@(posedge i_clk) disable iff (!i_rstn)
		(i_cfg.wr && i_cfg.addr[7:2] == 6'h23 && i_cfg.be[3:2] == 2'h3)
			##1 !i_cfg.wr ##1 s_rd_split
			|=> o_cfg_rdata[31:16] == $past(i_cfg.wdata[31:16], 3);
	endproperty
	a_limit_write: assert property (p_limit_write)
		else $error("commitment limit did not take the write");

	property p_delayed_set;
		@(posedge i_clk) disable iff (!i_rstn)
		o_held ##1 (i_cfg.rd && i_cfg.addr[7:2] == 6'h21) |=> o_cfg_rdata[21];
	endproperty
	a_delayed_set: assert property (p_delayed_set)
		else $error("delayed flag not set by held request");

	property p_pm_id;
		@(posedge i_clk) disable iff (!i_rstn)
		s_rd_pm |=> o_cfg_rdata[7:0] == 8'h01;
	endproperty
	a_pm_id: assert property (p_pm_id)
		else $error("capability identifier wrong");

	property p_next_ptr;
		@(posedge i_clk) disable iff (!i_rstn)
		s_rd_pm |=> o_cfg_rdata[15:8] == 8'ha8;
	endproperty
	a_next_ptr: assert property (p_next_ptr)
		else $error("next pointer wrong");

	property p_version;
		@(posedge i_clk) disable iff (!i_rstn)
		s_rd_pm |=> o_cfg_rdata[18:16] == 3'h3;
	endproperty
	a_version: assert property (p_version)
		else $error("version field wrong");

	property p_zero_flags;
		@(posedge i_clk) disable iff (!i_rstn)
		s_rd_pm |=> (!o_cfg_rdata[19] && !o_cfg_rdata[21]);
	endproperty
	a_zero_flags: assert property (p_zero_flags)
		else $error("wake-clock or init flag set");

	property p_no_d1_d2;
		@(posedge i_clk) disable iff (!i_rstn)
		s_rd_pm |=> o_cfg_rdata[26:25] == 2'h0;
	endproperty
	a_no_d1_d2: assert property (p_no_d1_d2)
		else $error("D1 or D2 support advertised");

	property p_wake_sup;
		@(posedge i_clk) disable iff (!i_rstn)
		s_rd_pm |=> o_cfg_rdata[31:27] == 5'h19;
	endproperty
	a_wake_sup: assert property (p_wake_sup)
		else $error("wake support field wrong");

	property p_ro_write;
		@(posedge i_clk) disable iff (!i_rstn)
		(i_cfg.wr && i_cfg.addr[7:2] == 6'h24) ##2 s_rd_pm
			|=> (o_cfg_ack && o_cfg_rdata == 32'hc8_43_a801);
	endproperty
	a_ro_write: assert property (p_ro_write)
		else $error("write altered read-only capability");

	property p_ack_every;
		@(posedge i_clk) disable iff (!i_rstn)
		(i_cfg.wr || i_cfg.rd) |=> o_cfg_ack;
	endproperty
	a_ack_every: assert property (p_ack_every)
		else $error("config access not acknowledged");

	// a bounded forward never leaves more outstanding than the limit allowed
	property p_outst_bounded;
		@(posedge i_clk) disable iff (!i_rstn)
		(o_fwd && ($past(s_r.limit) < 16'h0100)) |-> (outst <= $past(s_r.limit));
	endproperty
	a_outst_bounded: assert property (p_outst_bounded)
		else $error("outstanding count above commitment limit");

	property p_held_sets_flag;
		@(posedge i_clk) disable iff (!i_rstn)
		o_held |=> s_r.delayed;
	endproperty
	a_held_sets_flag: assert property (p_held_sets_flag)
		else $error("hold did not set delayed flag");

	property p_flag_clear;
		@(posedge i_clk) disable iff (!i_rstn)
		(i_cfg.wr && i_cfg.addr[7:2] == 6'h21 && i_cfg.be[2]
			&& i_cfg.wdata[21] && !o_held) |=> !s_r.delayed;
	endproperty
	a_flag_clear: assert property (p_flag_clear)
		else $error("write of one did not clear delayed flag");

endmodule : sbp_split_pm_regs

// File: sim/sbp_split_pm_regs_tb.sv
/*
 * sbp_split_pm_regs_tb: self-checking bench for the split budget register,
 * the split status flag and the read-only power-management capability word.
 * Assumes the sbp_pkg constants and the hand-over timing: config ack one cycle
 * after the strobe, forward pulse two cycles after a taken split request.
 */
module sbp_split_pm_regs_tb;
	timeunit 1ns;
	timeprecision 100ps;

	logic                  i_clk;
	logic                  i_rstn;
	sbp_pkg::sbp_cfg_req_t cfg;
	logic [31:0]           o_cfg_rdata;
	logic                  o_cfg_ack;
	logic                  req_valid;
	logic [15:0]           req_size;
	logic                  o_req_ready;
	logic                  rel_valid;
	logic [15:0]           rel_size;
	logic                  o_fwd;
	logic                  o_held;
	logic [31:0]           rd;
	int                    failures;
	int                    n_tests;

	sbp_split_pm_regs i_sbp_split_pm_regs (
		.i_clk       (i_clk),
		.i_rstn      (i_rstn),
		.i_cfg       (cfg),
		.o_cfg_rdata (o_cfg_rdata),
		.o_cfg_ack   (o_cfg_ack),
		.i_req_valid (req_valid),
		.i_req_size  (req_size),
		.o_req_ready (o_req_ready),
		.i_rel_valid (rel_valid),
		.i_rel_size  (rel_size),
		.o_fwd       (o_fwd),
		.o_held      (o_held)
	);

	always #50 i_clk = ~i_clk;

	task automatic finish_test;
		if (failures == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : finish_test

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	// one strobe, then a bounded wait for the ack; reads return via rd
	task automatic cfg_acc(input logic w, input logic [7:0] a, input logic [3:0] be,
			input logic [31:0] wd);
		int n;
		@(negedge i_clk);
		cfg = '{wr: w, rd: !w, addr: a, be: be, wdata: wd};
		@(negedge i_clk);
		cfg.wr = 1'b0;
		cfg.rd = 1'b0;
		// the ack stands one cycle only, so look before the next edge passes
		for (n = 0; n < 4; n++) begin
			if (o_cfg_ack === 1'b1) break;
			@(negedge i_clk);
		end
		if (n == 4) begin
			check("cfg_ack", 32'h1, 32'h0);
			finish_test();
		end else begin
			rd = o_cfg_rdata;
		end
	endtask : cfg_acc

	task automatic wait_fwd;
		int n;
		for (n = 0; n < 8; n++) begin
			@(posedge i_clk);
			#1;
			if (o_fwd === 1'b1) break;
		end
		if (n == 8) begin
			check("fwd_wait", 32'h1, 32'h0);
			finish_test();
		end
	endtask : wait_fwd

	// offer one request; the first outcome must be a forward or a hold as asked
	task automatic split_req(input logic [15:0] s, input logic want_fwd);
		int n;
		@(negedge i_clk);
		check("req_ready", 32'h1, {31'h0, o_req_ready});
		req_valid = 1'b1;
		req_size = s;
		@(negedge i_clk);
		req_valid = 1'b0;
		for (n = 0; n < 8; n++) begin
			@(posedge i_clk);
			#1;
			if (o_fwd === 1'b1 || o_held === 1'b1) break;
		end
		if (n == 8) begin
			check("gate_answer", 32'h1, 32'h0);
			finish_test();
		end else begin
			check("fwd", {31'h0, want_fwd}, {31'h0, o_fwd});
		end
	endtask : split_req

	task automatic release_adq(input logic [15:0] s);
		@(negedge i_clk);
		rel_valid = 1'b1;
		rel_size = s;
		@(negedge i_clk);
		rel_valid = 1'b0;
	endtask : release_adq

	task automatic t_reset_values;
		cfg_acc(1'b0, sbp_pkg::DS_SPLIT_OFF, 4'hf, 32'h0);
		check("split_reg", 32'h00100010, rd);
		cfg_acc(1'b0, sbp_pkg::PM_CAP_OFF, 4'hf, 32'h0);
		check("pm_cap", 32'hc843a801, rd);
		check("pm_wake_sup", 32'h19, {27'h0, rd[31:27]});
	endtask : t_reset_values

	task automatic t_read_only;
		cfg_acc(1'b1, sbp_pkg::PM_CAP_OFF, 4'hf, 32'h37bc57fe);
		cfg_acc(1'b0, sbp_pkg::PM_CAP_OFF, 4'hf, 32'h0);
		check("pm_cap_ro", 32'hc843a801, rd);
		cfg_acc(1'b1, sbp_pkg::DS_SPLIT_OFF, 4'h3, 32'h0000ffff);
		cfg_acc(1'b0, sbp_pkg::DS_SPLIT_OFF, 4'hf, 32'h0);
		check("split_cap_ro", 32'h00100010, rd);
		cfg_acc(1'b0, 8'h00, 4'hf, 32'h0);
		check("unmapped", 32'h0, rd);
	endtask : t_read_only

	// exact fill of the default limit, then one more adq must wait for a release
	task automatic t_held_and_flag;
		split_req(16'h0010, 1'b1);
		split_req(16'h0001, 1'b0);
		check("ready_held", 32'h0, {31'h0, o_req_ready});
		// the flag lands one cycle after the hold shows
		@(negedge i_clk);
		cfg_acc(1'b0, 8'h84, 4'hf, 32'h0);
		check("delayed_set", 32'h1, {31'h0, rd[sbp_pkg::DELAYED_BIT]});
		release_adq(16'h0010);
		wait_fwd();
		cfg_acc(1'b0, 8'h84, 4'hf, 32'h0);
		check("delayed_sticky", 32'h1, {31'h0, rd[sbp_pkg::DELAYED_BIT]});
		cfg_acc(1'b1, 8'h84, 4'h4, 32'h00200000);
		cfg_acc(1'b0, 8'h84, 4'hf, 32'h0);
		check("delayed_clr", 32'h0, {31'h0, rd[sbp_pkg::DELAYED_BIT]});
		release_adq(16'h0001);
	endtask : t_held_and_flag

	task automatic t_free_limits;
		cfg_acc(1'b1, sbp_pkg::DS_SPLIT_OFF, 4'hc, 32'h01000000);
		cfg_acc(1'b0, sbp_pkg::DS_SPLIT_OFF, 4'hf, 32'h0);
		check("limit_wr", 32'h01000010, rd);
		split_req(16'h0200, 1'b1);
		split_req(16'h0200, 1'b1);
		cfg_acc(1'b1, sbp_pkg::DS_SPLIT_OFF, 4'hc, 32'h00ff0000);
		split_req(16'h0001, 1'b0);
		// lifting the limit must free the request that is already waiting
		cfg_acc(1'b1, sbp_pkg::DS_SPLIT_OFF, 4'hc, 32'hffff0000);
		wait_fwd();
		split_req(16'h8000, 1'b1);
		cfg_acc(1'b0, sbp_pkg::DS_SPLIT_OFF, 4'hf, 32'h0);
		check("limit_all", 32'hffff0010, rd);
	endtask : t_free_limits

	initial begin
		i_clk = 1'b0;
		i_rstn = 1'b0;
		cfg = '0;
		req_valid = 1'b0;
		req_size = 16'h0;
		rel_valid = 1'b0;
		rel_size = 16'h0;
		failures = 0;
		n_tests = 0;
		repeat (12) @(negedge i_clk);
		i_rstn = 1'b1;
		t_reset_values();
		t_read_only();
		t_held_and_flag();
		t_free_limits();
		finish_test();
	end
endmodule : sbp_split_pm_regs_tb
